// >>> bench/ptd_test_ctrl_asserts.sv
module ptd_test_ctrl_asserts
(
    input wire logic clock,
    input wire logic rst_n,
    input wire ptd_pkg::ptd_req_t req,
    input wire ptd_pkg::ptd_cdr_t cdr,
    input wire logic osc_tick,
    input wire logic rec_tick,
    input wire logic auto_sleep,
    input wire logic auto_mute,
    input wire logic auto_disable,
    input wire logic [15:0] chk_errors,
    input wire logic chk_busy,
    input wire logic chk_done,
    input wire logic chk_aborted,
    input wire logic gen_data_valid,
    input wire logic gen_drive,
    input wire logic eye_point_busy,
    input wire logic eye_point_done,
    input wire logic [31:0] eye_dwell_us
);
    import ptd_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic clr;
    logic clr_q;
    logic [31:0] busy_cnt;
    logic [31:0] span;
    assign clr = req.wr && req.addr == OFS_CHK_CTRL && !req.wdata[CHK_RUN_BIT];
    // the cleared request reaches the state one cycle after the write
    always_ff @(posedge clock)
    begin
        clr_q <= rst_n && clr;
    end
    // two passes of 125 cycles per microsecond
    assign span = {eye_dwell_us[30:0], 1'b0} * 32'd125;
    always_ff @(posedge clock)
    begin
        if (!rst_n || !eye_point_busy)
            busy_cnt <= '0;
        else
            busy_cnt <= busy_cnt + 32'h0000_0001;
    end
    chk_abort_unlock: assert property (chk_busy && !cdr.locked |=> chk_aborted)
        else $error("abort did not follow loss of lock");
    chk_result_hold: assert property ((chk_done || chk_aborted) && !clr && !clr_q
        |=> $stable(chk_errors) && (chk_done || chk_aborted))
        else $error("checker result moved before clear");
    chk_clear_idle: assert property ((chk_done || chk_aborted) && clr
        |=> ##1 !(chk_busy || chk_done || chk_aborted))
        else $error("clear did not return checker to idle");
    chk_quiet_auto: assert property (auto_sleep || auto_mute || auto_disable |-> !gen_drive)
        else $error("generator drives while blocked");
    chk_tick_cause: assert property (gen_data_valid |-> $past(osc_tick || rec_tick))
        else $error("generator output without a tick");
    chk_dwell_hi: assert property (req.wr && req.addr == OFS_DWELL_HI
        |=> eye_dwell_us[31:16] == $past(req.wdata))
        else $error("upper dwell not written");
    chk_dwell_lo: assert property (req.wr && req.addr == OFS_DWELL_LO
        |=> eye_dwell_us[15:0] == $past(req.wdata))
        else $error("lower dwell not written");
    chk_dwell_rst: assert property ($rose(rst_n) |-> eye_dwell_us == 32'h0000_0064)
        else $error("dwell reset value wrong");
    chk_eye_span: assert property (eye_point_done && eye_dwell_us != 0
        |-> busy_cnt + 2 >= span && busy_cnt <= span + 2)
        else $error("eye point time not twice the dwell");
    cover property ($rose(chk_done));
    cover property ($rose(chk_aborted));
    cover property (eye_point_done);
endmodule : ptd_test_ctrl_asserts

bind ptd_test_ctrl ptd_test_ctrl_asserts chk_u (.clock, .rst_n, .req, .cdr, .osc_tick,
    .rec_tick, .auto_sleep, .auto_mute, .auto_disable, .chk_errors, .chk_busy, .chk_done,
    .chk_aborted, .gen_data_valid, .gen_drive, .eye_point_busy, .eye_point_done,
    .eye_dwell_us);

// >>> bench/ptd_test_ctrl_bench.sv
module ptd_test_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import ptd_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e;} ptd_row_t;
    logic clock, rst_n, osc_tick, rec_tick, auto_sleep, auto_mute, auto_disable;
    logic chk_bit, chk_bit_valid, chk_busy, chk_done, chk_aborted, gen_data, gen_data_valid;
    logic gen_drive, gen_rate_ok, eye_point_start, eye_point_busy, eye_point_done;
    logic [15:0] chk_errors, v;
    logic [2:0] gen_rate;
    logic [31:0] eye_dwell_us;
    logic [6:0] lf;
    logic [1:0] r;
    logic p;
    ptd_req_t req;
    ptd_rsp_t rsp;
    ptd_cdr_t cdr;
    int failures = 0;
    int total_checks = 0;
    int n, t;
    ptd_row_t rows [14] = '{'{1'b0, 8'h50, 16'h0000, 16'h0003}, '{1'b0, 8'h51, 16'h0000, 16'h0000},
        '{1'b0, 8'h52, 16'h0000, 16'h0106}, '{1'b0, 8'h53, 16'h0000, 16'h0000},
        '{1'b0, 8'h54, 16'h0000, 16'h0000}, '{1'b0, 8'h55, 16'h0000, 16'h0064},
        '{1'b0, 8'h5f, 16'h0000, 16'h0000}, '{1'b1, 8'h54, 16'hffff, 16'hffff},
        '{1'b1, 8'h55, 16'h1234, 16'h1234}, '{1'b1, 8'h52, 16'h03ff, 16'h03ff},
        '{1'b1, 8'h53, 16'h0000, 16'h0000}, '{1'b1, 8'h51, 16'h0100, 16'h0100},
        '{1'b1, 8'h50, 16'h0fff, 16'h0fff}, '{1'b1, 8'h60, 16'hffff, 16'h0000}};

    ptd_test_ctrl dut_u (.clock(clock), .rst_n(rst_n), .req(req), .rsp(rsp), .cdr(cdr),
        .osc_tick(osc_tick), .rec_tick(rec_tick), .auto_sleep(auto_sleep),
        .auto_mute(auto_mute), .auto_disable(auto_disable), .chk_bit(chk_bit),
        .chk_bit_valid(chk_bit_valid), .chk_errors(chk_errors), .chk_busy(chk_busy),
        .chk_done(chk_done), .chk_aborted(chk_aborted), .gen_data(gen_data),
        .gen_data_valid(gen_data_valid), .gen_drive(gen_drive), .gen_rate(gen_rate),
        .gen_rate_ok(gen_rate_ok), .eye_point_start(eye_point_start),
        .eye_point_busy(eye_point_busy), .eye_point_done(eye_point_done),
        .eye_dwell_us(eye_dwell_us));

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // never unknown, even if the first falling edge comes before any other setup
    always @(negedge clock)
        chk_bit <= (chk_bit !== 1'b1);

    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            failures++;
            $display("Error at %0t: seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic limit(input int cnt, input int lim);
        if (cnt >= lim)
        begin
            failures++;
            test_done();
        end
    endtask : limit

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clock);
        req = '{1'b1, 1'b0, a, d};
        @(negedge clock);
        req = '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clock);
        req = '{1'b0, 1'b1, a, 16'h0000};
        @(negedge clock);
        req = '0;
        check(rsp.valid, 1);
        d = rsp.rdata;
    endtask : rd

    // one tick per call, result sampled a cycle later
    task automatic tick(input logic rec, output logic [1:0] res);
        @(negedge clock);
        osc_tick = !rec;
        rec_tick = rec;
        @(negedge clock);
        osc_tick = 1'b0;
        rec_tick = 1'b0;
        res = {gen_data_valid, gen_data};
    endtask : tick

    task automatic wait_done(input int lim);
        n = 0;
        while (chk_done !== 1'b1 && n < lim)
        begin
            @(negedge clock);
            n++;
        end
        limit(n, lim);
    endtask : wait_done

    initial
    begin
        {rst_n, osc_tick, rec_tick, auto_sleep, auto_mute, auto_disable} = '0;
        {chk_bit_valid, eye_point_start} = '0;
        req = '0;
        cdr = '0;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        check(eye_dwell_us, 32'h0000_0064);
        foreach (rows[i])
        begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            check(v, rows[i].e);
        end
        check(eye_dwell_us, 32'hffff_1234);
        $display("test registers done");
        for (int inv = 0; inv < 2; inv++)
        begin
            wr(8'h52, 16'h0100);
            wr(8'h52, {12'h030, inv[0], 3'h1});
            lf = 7'h7f;
            repeat (20)
            begin
                tick(1'b0, r);
                check(r, {1'b1, lf[6] ^ inv[0]});
                lf = {lf[5:0], lf[6] ^ lf[5]};
            end
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h52, 16'h0100);
            wr(8'h52, {10'h008, k[1:0], 4'h1});
            tick(1'b0, r);
            p = r[0];
            t = 0;
            repeat (64)
            begin
                tick(1'b0, r);
                t += int'(r[0] != p);
                p = r[0];
            end
            check(t, 64 >> k);
        end
        cdr = '{1'b1, 3'h3};
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h52, {6'h00, 2'b11, s[1:0], 6'h01});
            tick(1'b0, r);
            check(r[1], s == 0);
            tick(1'b1, r);
            check(r[1], s == 3);
            check(gen_rate, (s == 3) ? 3 : 1);
            check(gen_rate_ok, s == 3);
        end
        cdr = '0;
        for (int rt = 0; rt < 8; rt++)
        begin
            wr(8'h52, {13'h0060, rt[2:0]});
            check(gen_rate, rt);
            check(gen_rate_ok, rt >= 1 && rt <= 4);
        end
        for (int i = 0; i < 4; i++)
        begin
            {auto_disable, auto_mute, auto_sleep} = 3'(1 << i);
            @(negedge clock);
            check(gen_drive, i == 3);
        end
        wr(8'h52, 16'h0100);
        check(gen_drive, 0);
        $display("test generator done");
        chk_bit_valid = 1'b1;
        wr(8'h51, 16'h0001);
        check({chk_busy, chk_done, chk_aborted}, 0);
        wr(8'h51, 16'h0000);
        chk_bit_valid = 1'b0;
        // two counted bits after the mode write, one of them a miss against an empty history
        check(chk_errors, 16'h0001);
        cdr = '{1'b1, 3'h3};
        wr(8'h50, 16'h0102);
        wr(8'h51, 16'h0101);
        wait_done(500);
        // one start cycle, then prescale 8 times interval 2
        check(n, 8 * 2 + 1);
        check(chk_errors, 0);
        repeat (5) @(negedge clock);
        check(chk_done, 1);
        wr(8'h51, 16'h0100);
        @(negedge clock);
        check({chk_busy, chk_done}, 0);
        wr(8'h51, 16'h0101);
        repeat (3) @(negedge clock);
        cdr.locked = 1'b0;
        @(negedge clock);
        check(chk_aborted, 1);
        repeat (3) @(negedge clock);
        check(chk_aborted, 1);
        wr(8'h51, 16'h0100);
        @(negedge clock);
        check(chk_aborted, 0);
        wr(8'h51, 16'h0101);
        @(negedge clock);
        check(chk_aborted, 1);
        wr(8'h51, 16'h0100);
        $display("test checker done");
        wr(8'h54, 16'h0000);
        wr(8'h55, 16'h0001);
        check(eye_dwell_us, 32'h0000_0001);
        @(negedge clock);
        eye_point_start = 1'b1;
        @(negedge clock);
        eye_point_start = 1'b0;
        check(eye_point_busy, 1);
        n = 0;
        while (eye_point_done !== 1'b1 && n < 1000)
        begin
            @(negedge clock);
            n++;
        end
        limit(n, 1000);
        check(n, 2 * CYC_PER_US);
        $display("test eye done");
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        check(eye_dwell_us, 32'h0000_0064);
        rd(8'h52, v);
        check(v, 16'h0106);
        $display("test reset done");
        test_done();
    end
endmodule : ptd_test_ctrl_bench

// >>> rtl/ptd_pkg.sv
// Function
// - checker_timed_select 0 runs the checker continuously, 1 runs one timed measurement.
// - a timed measurement in progress aborts when the recovery loop loses lock.
// - generator works only while generator_on is 1; generator_on resets to 0.
// - generator enable does not override auto sleep, mute or disable.
// - gen_output_choice 1 gives PRBS7 (reset), 0 gives a divided generator clock.
// - gen_clock_source 0 is free oscillator, 3 is recovered clock, 1 and 2 reserved.
// - gen_clock_ratio codes 0..3 divide the generator clock by 2, 4, 8, 16.
// - gen_pattern_invert 0 sends true sense, 1 sends the pattern inverted.
// - gen_rate_select 1 MADI, 2 SD, 3 HD, 4 3G; others reserved; resets to 6.
// - with recovered clock source the rate field is ignored, recovery rate used.
// - while locked only the locked rate is valid; host selects only that rate.
// - dwell time is 32 bits, upper half in one register, lower in the next.
// - dwell value is microseconds spent counting errors per eye point.
// - each point is measured twice, so time per point is twice the dwell.
// - lower dwell register resets to 0x64, upper dwell register resets to 0.
// - timed check uses prescale 4 (code 0) doubling to 2048 (code 9) times interval.
package ptd_pkg;
    localparam logic [7:0] OFS_CHK_CFG = 8'h50;
    localparam logic [7:0] OFS_CHK_CTRL = 8'h51;
    localparam logic [7:0] OFS_GEN_CTRL = 8'h52;
    localparam logic [7:0] OFS_RESERVED_GAP_GAP = 8'h53;
    localparam logic [7:0] OFS_DWELL_HI = 8'h54;
    localparam logic [7:0] OFS_DWELL_LO = 8'h55;
    localparam int CHK_RUN_BIT = 0;
    localparam int CHK_TIMED_BIT = 8;
    localparam int CFG_IVL_LSB = 0;
    localparam int CFG_PRE_LSB = 8;
    localparam int GEN_RATE_LSB = 0;
    localparam int GEN_INV_BIT = 3;
    localparam int GEN_RATIO_LSB = 4;
    localparam int GEN_SRC_LSB = 6;
    localparam int GEN_CHOICE_BIT = 8;
    localparam int GEN_ON_BIT = 9;
    localparam logic [3:0] PRE_MAX_CODE = 4'h9;
    localparam logic [10:0] PRE_BASE = 11'h004;
    localparam logic [7:0] RST_IVL = 8'h03;
    localparam logic [3:0] RST_PRE = 4'h0;
    localparam logic [2:0] RST_RATE = 3'h6;
    localparam logic [15:0] RST_DWELL_HI = 16'h0000;
    localparam logic [15:0] RST_DWELL_LO = 16'h0064;
    localparam logic [1:0] SRC_OSC = 2'h0;
    localparam logic [1:0] SRC_RECOVERED = 2'h3;
    localparam logic [2:0] RATE_MADI = 3'h1;
    localparam logic [2:0] RATE_3G = 3'h4;
    localparam logic [6:0] PRBS_SEED = 7'h7f;
    localparam int CLK_PERIOD_NS = 8;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] US_TICK_LAST = 7'(CYC_PER_US - 1);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } ptd_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } ptd_rsp_t;

    typedef struct packed {
        logic locked;
        logic [2:0] rate;
    } ptd_cdr_t;

    typedef enum logic [3:0] {
        CHK_IDLE = 4'b0001,
        CHK_RUN = 4'b0010,
        CHK_DONE = 4'b0100,
        CHK_ABORT = 4'b1000
    } ptd_chk_state_t;
endpackage : ptd_pkg

// >>> rtl/ptd_test_ctrl.sv
module ptd_test_ctrl
(
    input wire logic clock,
    input wire logic rst_n,
    input wire ptd_pkg::ptd_req_t req,
    output ptd_pkg::ptd_rsp_t rsp,
    input wire ptd_pkg::ptd_cdr_t cdr,
    input wire logic osc_tick,
    input wire logic rec_tick,
    input wire logic auto_sleep,
    input wire logic auto_mute,
    input wire logic auto_disable,
    input wire logic chk_bit,
    input wire logic chk_bit_valid,
    output logic [15:0] chk_errors,
    output logic chk_busy,
    output logic chk_done,
    output logic chk_aborted,
    output logic gen_data,
    output logic gen_data_valid,
    output logic gen_drive,
    output logic [2:0] gen_rate,
    output logic gen_rate_ok,
    input wire logic eye_point_start,
    output logic eye_point_busy,
    output logic eye_point_done,
    output logic [31:0] eye_dwell_us
);
    import ptd_pkg::*;

    logic [7:0] ivl_reg;
    logic [3:0] pre_reg;
    logic timed_reg;
    logic run_reg;
    logic gen_on_reg;
    logic choice_reg;
    logic [1:0] src_reg;
    logic [1:0] ratio_reg;
    logic inv_reg;
    logic [2:0] rate_reg;
    logic [15:0] dwell_hi_reg;
    logic [15:0] dwell_lo_reg;
    logic [15:0] rdata_next;

    // register writes; reserved bits are not stored and read back as zero
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ivl_reg <= RST_IVL;
            pre_reg <= RST_PRE;
            timed_reg <= 1'b0;
            run_reg <= 1'b0;
            gen_on_reg <= 1'b0;
            choice_reg <= 1'b1;
            src_reg <= SRC_OSC;
            ratio_reg <= 2'h0;
            inv_reg <= 1'b0;
            rate_reg <= RST_RATE;
            dwell_hi_reg <= RST_DWELL_HI;
            dwell_lo_reg <= RST_DWELL_LO;
        end
        else if (req.wr)
        begin
            unique case (req.addr)
                OFS_CHK_CFG:
                begin
                    ivl_reg <= req.wdata[CFG_IVL_LSB +: 8];
                    pre_reg <= req.wdata[CFG_PRE_LSB +: 4];
                end
                OFS_CHK_CTRL:
                begin
                    timed_reg <= req.wdata[CHK_TIMED_BIT];
                    run_reg <= req.wdata[CHK_RUN_BIT];
                end
                OFS_GEN_CTRL:
                begin
                    gen_on_reg <= req.wdata[GEN_ON_BIT];
                    choice_reg <= req.wdata[GEN_CHOICE_BIT];
                    src_reg <= req.wdata[GEN_SRC_LSB +: 2];
                    ratio_reg <= req.wdata[GEN_RATIO_LSB +: 2];
                    inv_reg <= req.wdata[GEN_INV_BIT];
                    rate_reg <= req.wdata[GEN_RATE_LSB +: 3];
                end
                OFS_DWELL_HI: dwell_hi_reg <= req.wdata;
                OFS_DWELL_LO: dwell_lo_reg <= req.wdata;
                default:
                begin
                end
            endcase
        end
    end

    always_comb
    begin
        rdata_next = 16'h0000;
        unique case (req.addr)
            OFS_CHK_CFG:
            begin
                rdata_next[CFG_IVL_LSB +: 8] = ivl_reg;
                rdata_next[CFG_PRE_LSB +: 4] = pre_reg;
            end
            OFS_CHK_CTRL:
            begin
                rdata_next[CHK_TIMED_BIT] = timed_reg;
                rdata_next[CHK_RUN_BIT] = run_reg;
            end
            OFS_GEN_CTRL:
            begin
                rdata_next[GEN_ON_BIT] = gen_on_reg;
                rdata_next[GEN_CHOICE_BIT] = choice_reg;
                rdata_next[GEN_SRC_LSB +: 2] = src_reg;
                rdata_next[GEN_RATIO_LSB +: 2] = ratio_reg;
                rdata_next[GEN_INV_BIT] = inv_reg;
                rdata_next[GEN_RATE_LSB +: 3] = rate_reg;
            end
            OFS_DWELL_HI: rdata_next = dwell_hi_reg;
            OFS_DWELL_LO: rdata_next = dwell_lo_reg;
            default: rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rsp <= '0;
        end
        else
        begin
            rsp.valid <= req.rd;
            rsp.rdata <= req.rd ? rdata_next : rsp.rdata;
        end
    end

    // checker: self-synchronising PRBS7 compare, x^7 + x^6 + 1
    logic [6:0] chk_hist_reg;
    logic chk_miss;
    ptd_chk_state_t chk_state_reg;
    logic [10:0] pre_cnt_reg;
    logic [7:0] ivl_cnt_reg;
    logic [10:0] pre_last;
    logic pre_wrap;
    logic [3:0] pre_code;
    logic chk_start;
    logic count_en;

    assign chk_miss = chk_bit ^ chk_hist_reg[6] ^ chk_hist_reg[5];
    // codes above 9 are not defined; clamp rather than overflow the prescaler
    assign pre_code = (pre_reg > PRE_MAX_CODE) ? PRE_MAX_CODE : pre_reg;
    assign pre_last = (PRE_BASE << pre_code) - 11'h001;
    assign pre_wrap = (pre_cnt_reg == pre_last);
    assign chk_start = timed_reg && run_reg && (chk_state_reg == CHK_IDLE);
    // continuous mode counts while idle; a timed result holds until the host clears it
    assign count_en = (chk_state_reg == CHK_RUN)
        || (!timed_reg && chk_state_reg == CHK_IDLE);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            chk_hist_reg <= 7'h00;
        end
        else if (chk_bit_valid)
        begin
            chk_hist_reg <= {chk_hist_reg[5:0], chk_bit};
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            chk_state_reg <= CHK_IDLE;
        end
        else
        begin
            unique case (chk_state_reg)
                CHK_IDLE:
                begin
                    if (chk_start)
                    begin
                        chk_state_reg <= cdr.locked ? CHK_RUN : CHK_ABORT;
                    end
                end
                CHK_RUN:
                begin
                    if (!cdr.locked)
                    begin
                        chk_state_reg <= CHK_ABORT;
                    end
                    else if (pre_wrap && (ivl_cnt_reg + 8'h01 >= ivl_reg))
                    begin
                        chk_state_reg <= CHK_DONE;
                    end
                end
                CHK_DONE, CHK_ABORT:
                begin
                    if (!run_reg)
                    begin
                        chk_state_reg <= CHK_IDLE;
                    end
                end
                default: chk_state_reg <= CHK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n || chk_state_reg != CHK_RUN)
        begin
            pre_cnt_reg <= 11'h000;
            ivl_cnt_reg <= 8'h00;
        end
        else if (pre_wrap)
        begin
            pre_cnt_reg <= 11'h000;
            ivl_cnt_reg <= ivl_cnt_reg + 8'h01;
        end
        else
        begin
            pre_cnt_reg <= pre_cnt_reg + 11'h001;
        end
    end

    // saturating error count; frozen outside the run in timed mode
    always_ff @(posedge clock)
    begin
        if (!rst_n || chk_start)
        begin
            chk_errors <= 16'h0000;
        end
        else if (count_en && chk_bit_valid && chk_miss && chk_errors != 16'hffff)
        begin
            chk_errors <= chk_errors + 16'h0001;
        end
    end

    assign chk_busy = (chk_state_reg == CHK_RUN);
    assign chk_done = (chk_state_reg == CHK_DONE);
    assign chk_aborted = (chk_state_reg == CHK_ABORT);

    // generator: tick from the selected source; reserved sources never tick
    logic gen_tick;
    logic [6:0] lfsr_reg;
    logic [3:0] div_reg;
    logic pattern_bit;

    always_comb
    begin
        gen_tick = 1'b0;
        if (gen_on_reg)
        begin
            if (src_reg == SRC_OSC)
            begin
                gen_tick = osc_tick;
            end
            else if (src_reg == SRC_RECOVERED)
            begin
                gen_tick = rec_tick;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n || !gen_on_reg)
        begin
            lfsr_reg <= PRBS_SEED;
            div_reg <= 4'h0;
        end
        else if (gen_tick)
        begin
            // an all-zero state would lock up the sequence, so reseed it
            lfsr_reg <= (lfsr_reg == 7'h00) ? PRBS_SEED
                : {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
            div_reg <= div_reg + 4'h1;
        end
    end

    // counter bit n toggles every 2^n ticks, so its period is 2^(n+1)
    assign pattern_bit = choice_reg ? lfsr_reg[6] : div_reg[ratio_reg];

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            gen_data <= 1'b0;
            gen_data_valid <= 1'b0;
        end
        else
        begin
            gen_data <= pattern_bit ^ inv_reg;
            gen_data_valid <= gen_tick;
        end
    end

    // automatic sleep, mute and disable still take precedence over the pattern
    assign gen_drive = gen_on_reg && !auto_sleep && !auto_mute && !auto_disable;

    always_comb
    begin
        gen_rate = (src_reg == SRC_RECOVERED) ? cdr.rate : rate_reg;
        gen_rate_ok = (gen_rate >= RATE_MADI) && (gen_rate <= RATE_3G)
            && (!cdr.locked || gen_rate == cdr.rate);
    end

    // eye dwell timer: one point spans two passes of the programmed microseconds
    logic [6:0] us_div_reg;
    logic [32:0] us_cnt_reg;
    logic us_tick;

    assign eye_dwell_us = {dwell_hi_reg, dwell_lo_reg};
    assign us_tick = (us_div_reg == US_TICK_LAST);

    always_ff @(posedge clock)
    begin
        if (!rst_n || !eye_point_busy || us_tick)
        begin
            us_div_reg <= 7'h00;
        end
        else
        begin
            us_div_reg <= us_div_reg + 7'h01;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            eye_point_busy <= 1'b0;
            eye_point_done <= 1'b0;
            us_cnt_reg <= 33'h0_0000_0000;
        end
        else
        begin
            eye_point_done <= 1'b0;
            if (!eye_point_busy)
            begin
                us_cnt_reg <= 33'h0_0000_0000;
                eye_point_busy <= eye_point_start;
            end
            else if (us_tick)
            begin
                if (us_cnt_reg + 33'h0_0000_0001 >= {eye_dwell_us, 1'b0})
                begin
                    eye_point_busy <= 1'b0;
                    eye_point_done <= 1'b1;
                end
                us_cnt_reg <= us_cnt_reg + 33'h0_0000_0001;
            end
        end
    end
endmodule : ptd_test_ctrl
